// ===== rtl/ebsl_top.sv
// External bus strobe logic: APB configuration, bus cycle sequencer and registered pin drivers.
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module ebsl_top #(
  parameter int unsigned WAIT_CNT_W = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        core_req,
  input  wire logic        core_write,
  input  wire logic        core_fetch,
  input  wire logic [23:0] core_addr,
  input  wire logic [1:0]  core_be,
  input  wire logic [15:0] core_wdata,
  output logic             core_idle,
  output logic             core_done,
  output logic      [15:0] core_rdata,
  input  wire logic        ready_in,
  input  wire logic        ext_fetch_select,
  output logic             boot_external,
  output logic             rd_strobe_n,
  output logic             write_strobe_low_n,
  output logic             high_byte_pin_n,
  output logic             ale,
  output logic      [7:0]  segment_port,
  output logic      [15:0] addr_port,
  output logic      [15:0] muxed_addr_data_port_out,
  output logic      [15:0] muxed_addr_data_port_oe_n,
  input  wire logic [15:0] muxed_addr_data_port_in,
  output logic             sys_clock_out
);

  ebsl_pkg::ebsl_state_e state_q, state_d;
  logic [4:0]            cfg_q;
  logic                  wr_q, lane_q, bus16_q, mux_q, rdyen_q;
  logic [1:0]            be_q;
  logic [23:0]           addr_q;
  logic [15:0]           wdata_q;
  logic [WAIT_CNT_W-1:0] wait_cnt_q, last_wait_q;
  logic                  captured_q;
  logic                  clk_en_n_q;
  logic [31:0]           prdata_q;
  logic                  pready_q, pslverr_q;
  logic                  idle_q, done_q;
  logic [15:0]           rdata_q;
  logic                  boot_q;
  logic                  rd_n_q, wrl_n_q, hi_n_q, ale_q;
  logic [7:0]            seg_q;
  logic [15:0]           aport_q, mout_q, moe_n_q;

  // APB decode.
  wire apb_setup  = psel && !penable;
  wire apb_access = psel && penable && pready_q;
  wire sel_cfg    = paddr == ebsl_pkg::OFS_SYS_CFG;
  wire sel_stat   = paddr == ebsl_pkg::OFS_STATUS;
  wire cfg_write  = ce && apb_access && pwrite && sel_cfg;
  wire [31:0] stat_word = {last_wait_q, 13'h0000, (state_q == ebsl_pkg::EBSL_STROBE) && rdyen_q && ready_in,
                           boot_q, state_q != ebsl_pkg::EBSL_IDLE};
  wire [31:0] rd_mux = sel_cfg  ? {27'h0000000, cfg_q} :
                       sel_stat ? stat_word : 32'h00000000;

  // Request selection: the cycle that accepts a request decodes from the core's inputs.
  wire take      = (state_q == ebsl_pkg::EBSL_IDLE) && core_req;
  wire cur_wr    = take ? (core_write && !core_fetch) : wr_q;
  wire [1:0] cur_be = take ? core_be : be_q;
  wire cur_lane  = take ? cfg_q[ebsl_pkg::CFG_WRMODE_BIT] : lane_q;
  wire cur_bus16 = take ? cfg_q[ebsl_pkg::CFG_BUS16_BIT] : bus16_q;
  wire cur_mux   = take ? cfg_q[ebsl_pkg::CFG_MUX_BIT] : mux_q;
  wire [23:0] cur_addr  = take ? core_addr : addr_q;
  wire [15:0] cur_wdata = take ? core_wdata : wdata_q;
  wire stretch   = rdyen_q && ready_in;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ebsl_pkg::EBSL_IDLE: begin
        if (core_req) begin
          state_d = cfg_q[ebsl_pkg::CFG_MUX_BIT] ? ebsl_pkg::EBSL_ALE : ebsl_pkg::EBSL_STROBE;
        end
      end
      ebsl_pkg::EBSL_ALE: begin
        state_d = ebsl_pkg::EBSL_STROBE;
      end
      ebsl_pkg::EBSL_STROBE: begin
        if (!stretch) begin
          state_d = ebsl_pkg::EBSL_RECOV;
        end
      end
      ebsl_pkg::EBSL_RECOV: begin
        state_d = ebsl_pkg::EBSL_IDLE;
      end
    endcase
  end

  logic rd_req, wr_lo_req, hi_en_req, hi_wr_req;
  ebsl_strobe_dec u_dec (
    .lane_mode (cur_lane),
    .bus16     (cur_bus16),
    .write     (cur_wr),
    .be        (cur_be),
    .rd_req    (rd_req),
    .wr_lo_req (wr_lo_req),
    .hi_en_req (hi_en_req),
    .hi_wr_req (hi_wr_req)
  );

  // Strobe, latch and data-port next values, all derived from the next state so that pins and state stay in step.
  wire d_busy   = state_d != ebsl_pkg::EBSL_IDLE;
  wire d_strobe = state_d == ebsl_pkg::EBSL_STROBE;
  wire d_ale    = state_d == ebsl_pkg::EBSL_ALE;
  wire d_data   = d_strobe || (state_d == ebsl_pkg::EBSL_RECOV);
  wire rd_n_d   = !(d_strobe && rd_req);
  wire wrl_n_d  = !(d_strobe && wr_lo_req);
  wire hi_n_d   = !((d_busy && hi_en_req) || (d_strobe && hi_wr_req));
  // An upper-byte-only write on an 8-bit bus travels on the low lane.
  wire [7:0] lo_byte = (!cur_bus16 && cur_be == 2'h2) ? cur_wdata[15:8] : cur_wdata[7:0];
  wire [7:0] hi_byte = cur_bus16 ? cur_wdata[15:8] : cur_addr[15:8];
  // Multiplexed: address in the latch phase, then data; demultiplexed: data only. An 8-bit bus keeps A8-A15 on the upper lane.
  wire [15:0] mout_d = d_ale ? cur_addr[15:0] : {hi_byte, lo_byte};
  wire lo_oe_d  = (d_ale && cur_mux) || (d_data && cur_wr);
  wire hi_oe_d  = (d_ale && cur_mux) || (d_data && (cur_bus16 ? cur_wr : cur_mux));
  wire [15:0] moe_n_d = {{8{!hi_oe_d}}, {8{!lo_oe_d}}};
  wire capture  = (state_q == ebsl_pkg::EBSL_STROBE) && !stretch;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ebsl_pkg::EBSL_IDLE;
      cfg_q   <= ebsl_pkg::CFG_RESET;
    end else if (ce) begin
      state_q <= state_d;
      if (cfg_write) begin
        cfg_q <= pwdata[ebsl_pkg::CFG_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q    <= 1'b0;
      be_q    <= 2'h0;
      lane_q  <= 1'b0;
      bus16_q <= 1'b0;
      mux_q   <= 1'b0;
      rdyen_q <= 1'b0;
      addr_q  <= 24'h000000;
      wdata_q <= 16'h0000;
    end else if (ce && take) begin
      wr_q    <= cur_wr;
      be_q    <= core_be;
      lane_q  <= cfg_q[ebsl_pkg::CFG_WRMODE_BIT];
      bus16_q <= cfg_q[ebsl_pkg::CFG_BUS16_BIT];
      mux_q   <= cfg_q[ebsl_pkg::CFG_MUX_BIT];
      rdyen_q <= cfg_q[ebsl_pkg::CFG_RDYEN_BIT];
      addr_q  <= core_addr;
      wdata_q <= core_wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_n_q  <= 1'b1;
      wrl_n_q <= 1'b1;
      hi_n_q  <= 1'b1;
      ale_q   <= 1'b0;
      seg_q   <= 8'h00;
      aport_q <= 16'h0000;
      mout_q  <= 16'h0000;
      moe_n_q <= 16'hffff;
    end else if (ce) begin
      rd_n_q  <= rd_n_d;
      wrl_n_q <= wrl_n_d;
      hi_n_q  <= hi_n_d;
      ale_q   <= d_ale;
      seg_q   <= cur_addr[23:16];
      aport_q <= cur_addr[15:0];
      mout_q  <= mout_d;
      moe_n_q <= moe_n_d;
    end
  end

  // Wait statistics and read capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt_q  <= '0;
      last_wait_q <= '0;
      rdata_q     <= 16'h0000;
      done_q      <= 1'b0;
      idle_q      <= 1'b1;
    end else if (ce) begin
      if (state_q == ebsl_pkg::EBSL_STROBE && stretch) begin
        wait_cnt_q <= wait_cnt_q + 1'b1;
      end else if (take) begin
        wait_cnt_q <= '0;
      end
      if (capture) begin
        last_wait_q <= wait_cnt_q;
        rdata_q     <= muxed_addr_data_port_in;
      end
      done_q <= state_q == ebsl_pkg::EBSL_RECOV;
      idle_q <= state_d == ebsl_pkg::EBSL_IDLE;
    end
  end

  // The select pin is caught on the first enabled edge after reset release, never by the reset itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      captured_q <= 1'b0;
      boot_q     <= 1'b0;
    end else if (ce && !captured_q) begin
      captured_q <= 1'b1;
      boot_q     <= !ext_fetch_select;
    end
  end

  // APB answers one cycle after setup, so every access takes exactly one access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      pready_q  <= apb_setup;
      pslverr_q <= apb_setup && !(sel_cfg || sel_stat);
      if (apb_setup) begin
        prdata_q <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  // The enable changes on the falling edge, while the clock is low, so the gated copy never glitches.
  always_ff @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_en_n_q <= 1'b1;
    end else begin
      clk_en_n_q <= !cfg_q[ebsl_pkg::CFG_CLKEN_BIT];
    end
  end
  assign sys_clock_out = pclk && !clk_en_n_q;

  assign prdata                    = prdata_q;
  assign pready                    = pready_q;
  assign pslverr                   = pslverr_q;
  assign core_idle                 = idle_q;
  assign core_done                 = done_q;
  assign core_rdata                = rdata_q;
  assign boot_external             = boot_q;
  assign rd_strobe_n               = rd_n_q;
  assign write_strobe_low_n        = wrl_n_q;
  assign high_byte_pin_n           = hi_n_q;
  assign ale                       = ale_q;
  assign segment_port              = seg_q;
  assign addr_port                 = aport_q;
  assign muxed_addr_data_port_out  = mout_q;
  assign muxed_addr_data_port_oe_n = moe_n_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire in_strobe = state_q == ebsl_pkg::EBSL_STROBE;

  AST_RD_STROBE: assert property (in_strobe |-> (rd_strobe_n == wr_q))
    else $error("read strobe does not follow access direction");
  AST_WR_COMBINED: assert property ((in_strobe && wr_q && !lane_q) |-> !write_strobe_low_n)
    else $error("combined mode write without low write strobe");
  AST_WR_LANE: assert property ((in_strobe && lane_q && bus16_q && !be_q[0]) |-> write_strobe_low_n)
    else $error("byte-lane low strobe on upper-only write");
  AST_CFG_MODE: assert property (cfg_write |=> (cfg_q[0] == $past(pwdata[0])))
    else $error("write mode bit not taken from configuration write");
  AST_HI_ENABLE: assert property ((state_q != ebsl_pkg::EBSL_IDLE && !lane_q && bus16_q && be_q[1])
                                  |-> !high_byte_pin_n)
    else $error("high byte enable missing");
  AST_HI_WRITE: assert property ((state_q != ebsl_pkg::EBSL_IDLE && lane_q)
                                 |-> (high_byte_pin_n == !(in_strobe && wr_q && bus16_q && be_q[1])))
    else $error("high byte write strobe wrong");
  AST_READY_HOLD: assert property ((ce && in_strobe && rdyen_q && ready_in) |=> in_strobe)
    else $error("access ended while ready held high");
  AST_READY_END: assert property ((ce && in_strobe && !(rdyen_q && ready_in))
                                  |=> (state_q == ebsl_pkg::EBSL_RECOV) ##1 (!ce || idle_q))
    else $error("access not ended after ready low");
  AST_ALE_PULSE: assert property ((ce && take && cfg_q[2]) |=> ale ##1 (!ce or !ale))
    else $error("address latch pulse wrong");
  AST_BOOT: assert property ($rose(captured_q) |-> (boot_external == !$past(ext_fetch_select)))
    else $error("boot source not taken from select pin");
  AST_SEGMENT: assert property ((state_q != ebsl_pkg::EBSL_IDLE) |-> (segment_port == addr_q[23:16]))
    else $error("segment lines do not carry A16 to A23");
  AST_MUX_ADDR: assert property ((state_q == ebsl_pkg::EBSL_ALE)
                                 |-> (muxed_addr_data_port_out == addr_q[15:0] && muxed_addr_data_port_oe_n == 16'h0000))
    else $error("address not driven in latch phase");

  COV_READ_WAIT: cover property (in_strobe && !wr_q && rdyen_q && ready_in ##1 in_strobe);
  COV_LANE_HI_WRITE: cover property (in_strobe && lane_q && wr_q && !high_byte_pin_n);
  COV_DEMUX_ACCESS: cover property (take && !cfg_q[2] ##1 in_strobe);
endmodule

// ===== rtl/ebsl_pkg.sv
// Constants for the external bus strobe logic: register map, fields, reset values.
package ebsl_pkg;
  localparam int unsigned APB_AW = 12;
  localparam logic [11:0] OFS_SYS_CFG = 12'h000;
  localparam logic [11:0] OFS_STATUS  = 12'h004;
  localparam int unsigned CFG_WRMODE_BIT = 0;
  localparam int unsigned CFG_RDYEN_BIT  = 1;
  localparam int unsigned CFG_MUX_BIT    = 2;
  localparam int unsigned CFG_BUS16_BIT  = 3;
  localparam int unsigned CFG_CLKEN_BIT  = 4;
  localparam int unsigned CFG_W          = 5;
  localparam logic [4:0] CFG_RESET = 5'h0c;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_BOOT_BIT = 1;
  localparam int unsigned ST_WAIT_BIT = 2;
  localparam int unsigned ST_LASTW_LSB = 16;
  typedef enum logic [1:0] {
    EBSL_IDLE,
    EBSL_ALE,
    EBSL_STROBE,
    EBSL_RECOV
  } ebsl_state_e;
endpackage

// ===== rtl/ebsl_strobe_dec.sv
// Decoder from access type and write mode to the raw strobe requests.
`timescale 1ns/10ps
module ebsl_strobe_dec (
  input  wire logic       lane_mode,
  input  wire logic       bus16,
  input  wire logic       write,
  input  wire logic [1:0] be,
  output logic            rd_req,
  output logic            wr_lo_req,
  output logic            hi_en_req,
  output logic            hi_wr_req
);
  // Fetches arrive with write low, so they read like data reads.
  assign rd_req    = !write;
  // Combined mode strobes every write; byte-lane mode only the low lane on a wide bus.
  assign wr_lo_req = write && (!lane_mode || !bus16 || be[0]);
  assign hi_en_req = !lane_mode && bus16 && be[1];
  assign hi_wr_req = lane_mode && write && bus16 && be[1];
endmodule

// ===== bench/ebsl_mem_model.sv
// Behavioural external memory on the far side of the bus: read data and ready.
`timescale 1ns/10ps
module ebsl_mem_model (
  input  wire logic        pclk,
  input  wire logic        rd_strobe_n,
  input  wire logic        write_strobe_low_n,
  input  wire logic        high_byte_pin_n,
  input  wire logic        ale,
  input  wire logic [15:0] addr_port,
  input  wire logic [3:0]  waits,
  output logic      [15:0] data_in,
  output logic             ready_in
);
  logic [3:0]  cnt_q;
  logic [15:0] last_q = 16'h0000;
  wire         strobe;
  // The address phase is left out so that a high-byte enable there does not eat a wait.
  assign strobe = (!rd_strobe_n || !write_strobe_low_n || !high_byte_pin_n) && !ale;
  // The pin has a pull-up, so ready reads high whenever the memory is not in a strobe.
  assign ready_in = !strobe || (cnt_q < waits);
  // A released bus must not show a stale copy of the last read.
  assign data_in = !rd_strobe_n ? (addr_port ^ 16'h5a5a) : ~last_q;
  always @(posedge pclk) begin
    cnt_q <= strobe ? cnt_q + 4'h1 : 4'h0;
    if (!rd_strobe_n) begin
      last_q <= addr_port ^ 16'h5a5a;
    end
  end
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the external bus strobe logic against a memory model.
`timescale 1ns/10ps
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic        core_req, core_write, core_fetch, core_idle, core_done, e;
  logic [23:0] core_addr;
  logic [1:0]  core_be;
  logic [15:0] core_wdata, core_rdata, addr_port, mad_out, mad_oe_n, mad_in;
  logic        ready_in, ext_fetch_select, boot_external, rd_strobe_n, write_strobe_low_n;
  logic        high_byte_pin_n, ale, sys_clock_out;
  logic [7:0]  segment_port;
  logic [3:0]  waits;
  int          miscompares, compares, seed, i;

  ebsl_top dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_req(core_req),
    .core_write(core_write), .core_fetch(core_fetch), .core_addr(core_addr), .core_be(core_be),
    .core_wdata(core_wdata), .core_idle(core_idle), .core_done(core_done), .core_rdata(core_rdata),
    .ready_in(ready_in), .ext_fetch_select(ext_fetch_select), .boot_external(boot_external),
    .rd_strobe_n(rd_strobe_n), .write_strobe_low_n(write_strobe_low_n), .high_byte_pin_n(high_byte_pin_n),
    .ale(ale), .segment_port(segment_port), .addr_port(addr_port), .muxed_addr_data_port_out(mad_out),
    .muxed_addr_data_port_oe_n(mad_oe_n), .muxed_addr_data_port_in(mad_in), .sys_clock_out(sys_clock_out));

  ebsl_mem_model mem (.pclk(pclk), .rd_strobe_n(rd_strobe_n), .write_strobe_low_n(write_strobe_low_n),
    .high_byte_pin_n(high_byte_pin_n), .ale(ale), .addr_port(addr_port), .waits(waits), .data_in(mad_in),
    .ready_in(ready_in));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    if (n >= 50) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task do_reset(input logic sel);
    presetn <= 1'b0;
    ext_fetch_select <= sel;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1 chk(boot_external, !sel);
    @(posedge pclk);
    apb(1'b0, ebsl_pkg::OFS_STATUS, 32'h0);
    chk(r[ebsl_pkg::ST_BOOT_BIT], !sel);
  endtask

  task access(input logic [4:0] cfg, input int kind, input logic [23:0] a, input logic [1:0] be,
              input logic [15:0] wd, input logic [3:0] w);
    logic lane, mux, b16, rd, in_s;
    int   s0, wt, k;
    lane = cfg[ebsl_pkg::CFG_WRMODE_BIT];
    mux = cfg[ebsl_pkg::CFG_MUX_BIT];
    b16 = cfg[ebsl_pkg::CFG_BUS16_BIT];
    rd = kind != 1;
    wt = cfg[ebsl_pkg::CFG_RDYEN_BIT] ? int'(w) : 0;
    s0 = mux ? 2 : 1;
    apb(1'b1, ebsl_pkg::OFS_SYS_CFG, {27'h0, cfg});
    apb(1'b0, ebsl_pkg::OFS_SYS_CFG, 32'h0);
    chk(r, {27'h0, cfg});
    waits <= w;
    core_req <= 1'b1;
    core_write <= kind != 0;
    core_fetch <= kind == 2;
    core_addr <= a;
    core_be <= be;
    core_wdata <= wd;
    @(posedge pclk);
    core_req <= 1'b0;
    // Cycle k is the k-th cycle after the taking edge; pins are looked at 1 ns into it.
    for (k = 1; k <= s0 + wt + 2; k++) begin
      #1 in_s = k >= s0 && k <= s0 + wt;
      chk(rd_strobe_n, !(in_s && rd));
      chk(write_strobe_low_n, !(in_s && !rd && (!lane || !b16 || be[0])));
      chk(high_byte_pin_n, !(b16 && be[1] && (lane ? in_s && !rd : k <= s0 + wt + 1)));
      chk(ale, mux && k == 1);
      chk(core_done, k == s0 + wt + 2);
      chk(core_idle, k == s0 + wt + 2);
      if (k == 1 && mux) chk(mad_out, a[15:0]);
      if (in_s) chk(segment_port, a[23:16]);
      if (in_s && !mux) chk(addr_port, a[15:0]);
      if (in_s) chk(mad_oe_n[7:0], rd ? 8'hff : 8'h00);
      if (in_s && !rd) chk(mad_out[7:0], (!b16 && be == 2'b10) ? wd[15:8] : wd[7:0]);
      if (k == 1) begin
        chk(sys_clock_out, cfg[ebsl_pkg::CFG_CLKEN_BIT]);
        #2 chk(sys_clock_out, 1'b0);
      end
      @(posedge pclk);
    end
    if (rd && b16) chk(core_rdata, a[15:0] ^ 16'h5a5a);
    if (rd && !b16) chk(core_rdata[7:0], a[7:0] ^ 8'h5a);
  endtask

  initial begin
    logic [4:0]  cfg;
    logic [1:0]  be;
    miscompares = 0;
    compares = 0;
    seed = 32'h83b6f552;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    core_req = 1'b0;
    core_write = 1'b0;
    core_fetch = 1'b0;
    core_addr = 24'h0;
    core_be = 2'h0;
    core_wdata = 16'h0;
    ext_fetch_select = 1'b0;
    waits = 4'h0;
    do_reset(1'b0);
    apb(1'b0, ebsl_pkg::OFS_SYS_CFG, 32'h0);
    chk(r, {27'h0, ebsl_pkg::CFG_RESET});
    // An unmapped word must be refused and read as zero.
    apb(1'b0, 12'h008, 32'h0);
    chk(e, 1'b1);
    chk(r, 32'h0);
    for (i = 0; i < 64; i++) begin
      cfg = i < 32 ? i[4:0] : 5'($random(seed));
      be = 2'($random(seed));
      if (be == 2'b00) be = 2'b11;
      // Upper-byte-only writes are the awkward case for the write strobes.
      if (i % 4 == 1) be = 2'b10;
      access(cfg, i % 3, 24'($random(seed)), be, 16'($random(seed)), 4'($random(seed) & 3));
      $display("test %0d done", i);
    end
    do_reset(1'b1);
    results();
  end

  initial begin
    #200000;
    miscompares++;
    results();
  end
endmodule
